//--- mioc_regs.vh
// Constants for the machine I/O control block: register offsets, fields, resets, timing.
// Assumes a 50 MHz core clock and a plain strobe register port with 4-bit word addresses.
`ifndef MIOC_REGS_VH
`define MIOC_REGS_VH

`define MIOC_CLK_HZ         50000000
`define MIOC_PEDAL_HOLD_MS  100
`define MIOC_PEDAL_CYCLES   ((`MIOC_CLK_HZ / 1000) * `MIOC_PEDAL_HOLD_MS)

`define MIOC_ADDR_W         4
`define MIOC_OFF_CTRL       4'h0
`define MIOC_OFF_LAYER      4'h1
`define MIOC_OFF_STATUS     4'h2
`define MIOC_OFF_IRQ_STAT   4'h3
`define MIOC_OFF_IRQ_MASK   4'h4
`define MIOC_OFF_INPUTS     4'h5

// Control register fields
`define MIOC_CTRL_BLOW_EN   0
`define MIOC_CTRL_PROT_EN   1
`define MIOC_CTRL_LMT_POL   2
`define MIOC_CTRL_SPECIAL   3
`define MIOC_CTRL_CMD_START 4
`define MIOC_CTRL_CMD_PAUSE 5
`define MIOC_CTRL_CMD_STOP  6
`define MIOC_CTRL_CMD_DONE  7
`define MIOC_CTRL_RESET     8'h00

// Job states
`define MIOC_ST_IDLE        2'h0
`define MIOC_ST_RUN         2'h1
`define MIOC_ST_PAUSE       2'h2

// Event bits
`define MIOC_EV_PEDAL       0
`define MIOC_EV_PROTECT     1
`define MIOC_EV_LIMIT       2
`define MIOC_EV_DONE        3
`define MIOC_EV_W           4

`endif

//--- mioc_machine_io_control.v
// Machine I/O control: job state, pedal qualification, protection, blower, laser and limit logic.
// Assumes inputs synchronous-capable pins, a plain strobe register port and a 50 MHz clock.
//
// Summary of operation
// - Job-running output goes active while a job is executing.
// - Pause keeps job-running output; completion or stop drives it inactive (here a completion write acts only while running and is ignored while paused).
// - Blower enabled: output follows blower control; disabled: special function bit.
// - Blower on/off comes from a per-layer setting of the running layer.
// - Blower output active while blower on, inactive while off.
// - Pedal press accepted only after 100 ms continuous low.
// - Accepted press starts idle job, pauses running job, resumes paused job.
// - A press beginning under 100 ms after previous press is ignored.
// - Protection input has an enable; disabled means not sampled, no action.
// - Manual fire laser while manual-fire input low; off when high.
// - Each axis has min and max limit inputs, identical layout per pair.
// - Default polarity: low means limit reached, indicator lit.
// - Polarity selectable; decides homing limit detection and indicator state.
// - Spare outputs stay inactive; spare input ignored.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mioc_regs.vh"

module mioc_machine_io_control #(
	parameter N_AXES        = 4,
	parameter N_LAYERS      = 8,
	parameter PEDAL_CYCLES  = `MIOC_PEDAL_CYCLES
) (
	// Clock and reset
	input  wire                      i_core_clk,
	input  wire                      i_arst_n,
	// Register port
	input  wire [`MIOC_ADDR_W-1:0]   i_addr,
	input  wire [31:0]               i_wdata,
	input  wire                      i_wr,
	input  wire                      i_rd,
	output reg  [31:0]               o_rdata,
	output reg                       o_irq,
	// Machine inputs, raw pins
	input  wire                      i_pedal_in_n,
	input  wire                      i_protect_in,
	input  wire                      i_fire_in_n,
	input  wire                      i_spare_in,
	input  wire [N_AXES-1:0]         i_min_limit,
	input  wire [N_AXES-1:0]         i_max_limit,
	// From the motion core
	input  wire [2:0]                i_layer,
	input  wire                      i_homing,
	// Machine outputs
	output reg                       o_job_run,
	output reg                       o_blower,
	output reg                       o_laser_on,
	output reg                       o_spare_out_a,
	output reg                       o_spare_out_b,
	output reg  [N_AXES-1:0]         o_min_led,
	output reg  [N_AXES-1:0]         o_max_led,
	output reg  [N_AXES-1:0]         o_min_hit,
	output reg  [N_AXES-1:0]         o_max_hit,
	output reg                       o_paused
);

	localparam NIN = 3 + 2 * N_AXES;
	// A zero hold count could never qualify a press, so one cycle is the floor
	localparam [31:0] HOLD = (PEDAL_CYCLES < 1) ? 32'h1 : PEDAL_CYCLES;

	// Two-flop synchroniser for every pin; spare input deliberately excluded
	// Flops reset high, the released level of pedal, fire and limits, so no false press or limit edge follows reset
	wire [NIN-1:0] raw_w = {i_max_limit, i_min_limit, i_fire_in_n, i_protect_in, i_pedal_in_n};
	reg  [NIN-1:0] sync1_q;
	reg  [NIN-1:0] sync2_q;
	always @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sync1_q <= {NIN{1'b1}};
			sync2_q <= {NIN{1'b1}};
		end
		else
		begin
			sync1_q <= raw_w;
			sync2_q <= sync1_q;
		end
	end

	wire              pedal_low_w = ~sync2_q[0];
	wire              prot_w      = sync2_q[1];
	wire              fire_low_w  = ~sync2_q[2];
	wire [N_AXES-1:0] min_w       = sync2_q[3 +: N_AXES];
	wire [N_AXES-1:0] max_w       = sync2_q[3+N_AXES +: N_AXES];

	// Registers
	reg [7:0]          ctrl_q;
	reg [N_LAYERS-1:0] layer_q;
	reg [`MIOC_EV_W-1:0] irq_stat_q;
	reg [`MIOC_EV_W-1:0] irq_mask_q;
	reg [1:0]          state_q;
	reg [1:0]          state_d;
	reg [31:0]         hold_cnt_q;
	reg [31:0]         gap_cnt_q;
	reg                pressed_q;
	reg                prot_act_q;

	// Command bits act only in the cycle of the write
	wire wr_ctrl_w = i_wr && (i_addr == `MIOC_OFF_CTRL);
	wire cmd_start = wr_ctrl_w && i_wdata[`MIOC_CTRL_CMD_START];
	wire cmd_pause = wr_ctrl_w && i_wdata[`MIOC_CTRL_CMD_PAUSE];
	wire cmd_stop  = wr_ctrl_w && i_wdata[`MIOC_CTRL_CMD_STOP];
	wire cmd_done  = wr_ctrl_w && i_wdata[`MIOC_CTRL_CMD_DONE];

	// Pedal qualification: hold counter for the press, gap counter from last press start
	wire press_begin_w = pedal_low_w && (hold_cnt_q == 32'h0);
	wire gap_ok_w      = (gap_cnt_q >= HOLD);
	reg  press_valid_q;
	wire pedal_evt_w   = pedal_low_w && press_valid_q && !pressed_q && (hold_cnt_q == HOLD - 32'h1);

	always @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			hold_cnt_q    <= 32'h0;
			gap_cnt_q     <= 32'hFFFFFFFF;
			pressed_q     <= 1'b0;
			press_valid_q <= 1'b0;
		end
		else
		begin
			if (!pedal_low_w)
			begin
				hold_cnt_q <= 32'h0; // short lows are dropped
				pressed_q  <= 1'b0;
			end
			// Saturate at the event count; pressed_q keeps a held pedal to one event
			else if (hold_cnt_q != HOLD - 32'h1)
				hold_cnt_q <= hold_cnt_q + 32'h1;
			if (pedal_evt_w)
				pressed_q <= 1'b1;
			// Spacing is judged at the press start and kept for the whole press
			if (press_begin_w)
			begin
				press_valid_q <= gap_ok_w;
				gap_cnt_q     <= 32'h0;
			end
			// Stops once the quiet time is met, so it cannot wrap
			else if (!gap_ok_w)
				gap_cnt_q <= gap_cnt_q + 32'h1;
		end
	end

	// Protection only looked at when enabled
	wire prot_trip_w = ctrl_q[`MIOC_CTRL_PROT_EN] && prot_w;

	// Job state machine
	// Software commands and the pedal share one path; protection blocks any start
	always @*
	begin
		state_d = state_q;
		case (state_q)
			`MIOC_ST_IDLE:
				if ((pedal_evt_w || cmd_start) && !prot_trip_w)
					state_d = `MIOC_ST_RUN;
			`MIOC_ST_RUN:
				if (cmd_stop || cmd_done)
					state_d = `MIOC_ST_IDLE;
				else if (pedal_evt_w || cmd_pause || prot_trip_w)
					state_d = `MIOC_ST_PAUSE;
			`MIOC_ST_PAUSE:
				if (cmd_stop)
					state_d = `MIOC_ST_IDLE;
				else if ((pedal_evt_w || cmd_start) && !prot_trip_w)
					state_d = `MIOC_ST_RUN;
			default:
				state_d = `MIOC_ST_IDLE;
		endcase
	end

	// Limit detection per axis with selectable polarity
	// Homing and the indicators see the same polarity-corrected level
	wire [N_AXES-1:0] min_hit_w;
	wire [N_AXES-1:0] max_hit_w;
	genvar g;
	generate
		for (g = 0; g < N_AXES; g = g + 1)
		begin : g_axis
			assign min_hit_w[g] = ctrl_q[`MIOC_CTRL_LMT_POL] ? min_w[g] : ~min_w[g];
			assign max_hit_w[g] = ctrl_q[`MIOC_CTRL_LMT_POL] ? max_w[g] : ~max_w[g];
		end
	endgenerate

	// Events are one-cycle pulses collected into the sticky status
	reg [N_AXES*2-1:0] hit_prev_q;
	wire limit_evt_w = |({max_hit_w, min_hit_w} & ~hit_prev_q);
	wire prot_evt_w  = prot_trip_w && !prot_act_q;
	wire done_evt_w  = (state_q != `MIOC_ST_IDLE) && (state_d == `MIOC_ST_IDLE);
	wire [`MIOC_EV_W-1:0] ev_w = {done_evt_w, limit_evt_w, prot_evt_w, pedal_evt_w};

	wire blow_layer_w = layer_q[i_layer[2:0]];

	// Next status and mask feed the interrupt flop, so the line drops on the edge of the read-clear
	reg [`MIOC_EV_W-1:0] irq_stat_d;
	reg [`MIOC_EV_W-1:0] irq_mask_d;
	always @*
	begin
		irq_mask_d = irq_mask_q;
		if (i_wr && (i_addr == `MIOC_OFF_IRQ_MASK))
			irq_mask_d = i_wdata[`MIOC_EV_W-1:0];
		// A read clears status, but an event in the same cycle still lands
		if (i_rd && (i_addr == `MIOC_OFF_IRQ_STAT))
			irq_stat_d = ev_w;
		else
			irq_stat_d = irq_stat_q | ev_w;
	end

	// Read mux; unmapped offsets and idle cycles give zero
	reg [31:0] rdata_d;
	always @*
	begin
		rdata_d = 32'h0;
		if (i_rd)
		begin
			case (i_addr)
				`MIOC_OFF_CTRL:     rdata_d = {24'h0, ctrl_q};
				`MIOC_OFF_LAYER:    rdata_d = {{(32-N_LAYERS){1'b0}}, layer_q};
				`MIOC_OFF_STATUS:   rdata_d = {28'h0, prot_act_q, pressed_q, state_q};
				`MIOC_OFF_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
				`MIOC_OFF_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
				`MIOC_OFF_INPUTS:   rdata_d = {{(29-2*N_AXES){1'b0}}, max_hit_w, min_hit_w, ~fire_low_w, prot_w, ~pedal_low_w};
				default:            rdata_d = 32'h0;
			endcase
		end
	end

	// Configuration, job state and interrupt registers
	always @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ctrl_q     <= `MIOC_CTRL_RESET;
			layer_q    <= {N_LAYERS{1'b0}};
			irq_mask_q <= {`MIOC_EV_W{1'b0}};
			irq_stat_q <= {`MIOC_EV_W{1'b0}};
			state_q    <= `MIOC_ST_IDLE;
			prot_act_q <= 1'b0;
			hit_prev_q <= {N_AXES*2{1'b0}};
			o_irq      <= 1'b0;
			o_rdata    <= 32'h0;
		end
		else
		begin
			state_q    <= state_d;
			prot_act_q <= prot_trip_w;
			hit_prev_q <= {max_hit_w, min_hit_w};
			if (wr_ctrl_w)
				ctrl_q <= {4'h0, i_wdata[3:0]}; // Command bits are self-clearing
			if (i_wr && (i_addr == `MIOC_OFF_LAYER))
				layer_q <= i_wdata[N_LAYERS-1:0];
			irq_mask_q <= irq_mask_d;
			irq_stat_q <= irq_stat_d;
			o_irq      <= |(irq_stat_d & irq_mask_d);
			o_rdata    <= rdata_d; // Stands for one cycle, then returns to zero
		end
	end

	// Machine outputs, each straight from a flop
	always @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_job_run     <= 1'b0;
			o_blower      <= 1'b0;
			o_laser_on    <= 1'b0;
			o_spare_out_a <= 1'b0;
			o_spare_out_b <= 1'b0;
			o_min_led     <= {N_AXES{1'b0}};
			o_max_led     <= {N_AXES{1'b0}};
			o_min_hit     <= {N_AXES{1'b0}};
			o_max_hit     <= {N_AXES{1'b0}};
			o_paused      <= 1'b0;
		end
		else
		begin
			// Running and paused both keep the job output on
			o_job_run <= (state_d != `MIOC_ST_IDLE);
			o_paused  <= (state_d == `MIOC_ST_PAUSE);
			// Blower only runs with the job; the special function is a software level
			if (ctrl_q[`MIOC_CTRL_BLOW_EN])
				o_blower <= (state_d == `MIOC_ST_RUN) && blow_layer_w;
			else
				o_blower <= ctrl_q[`MIOC_CTRL_SPECIAL];
			// Protection overrides the manual fire button
			o_laser_on    <= fire_low_w && !prot_trip_w;
			// Spares have no function; held low so attached relays stay off
			o_spare_out_a <= 1'b0;
			o_spare_out_b <= 1'b0;
			o_min_led     <= min_hit_w;
			o_max_led     <= max_hit_w;
			o_min_hit     <= min_hit_w & {N_AXES{i_homing}};
			o_max_hit     <= max_hit_w & {N_AXES{i_homing}};
		end
	end

endmodule

//--- mioc_asserts.sv
// Concurrent checks on the machine I/O control ports.
// Assumes one core clock; bound into the design at the foot of this file.
`timescale 1ns/1ps
module mioc_asserts #(
	parameter N_AXES = 4
) (
	// Clock and reset
	input wire              i_core_clk,
	input wire              i_arst_n,
	// Watched ports
	input wire              i_rd,
	input wire [31:0]       o_rdata,
	input wire              i_fire_in_n,
	input wire              i_protect_in,
	input wire              i_homing,
	input wire              o_laser_on,
	input wire              o_job_run,
	input wire              o_paused,
	input wire              o_spare_out_a,
	input wire              o_spare_out_b,
	input wire [N_AXES-1:0] o_min_led,
	input wire [N_AXES-1:0] o_max_led,
	input wire [N_AXES-1:0] o_min_hit,
	input wire [N_AXES-1:0] o_max_hit
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	// Four cycles cover the two synchroniser flops plus the output register
	sequence s_fire_off;
		i_fire_in_n [*4];
	endsequence
	sequence s_fire_on;
		(!i_fire_in_n && !i_protect_in) [*4];
	endsequence
	a_spare_quiet: assert property (!o_spare_out_a && !o_spare_out_b) else $error("spare output active");
	a_fire_off: assert property (s_fire_off |=> !o_laser_on) else $error("laser on with fire released");
	a_fire_on: assert property (s_fire_on |=> o_laser_on) else $error("laser off with fire held");
	a_pause_keeps_run: assert property (o_paused |-> o_job_run) else $error("pause dropped job output");
	a_min_hit_led: assert property ((o_min_hit & ~o_min_led) == '0) else $error("min hit without led");
	a_max_hit_led: assert property ((o_max_hit & ~o_max_led) == '0) else $error("max hit without led");
	a_hit_needs_homing: assert property (!i_homing [*3] |=> (o_min_hit | o_max_hit) == '0)
		else $error("limit hit outside homing");
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside read");
endmodule
bind mioc_machine_io_control mioc_asserts #(.N_AXES(N_AXES)) u_mioc_asserts (
	.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_fire_in_n(i_fire_in_n), .i_protect_in(i_protect_in), .i_homing(i_homing),
	.o_laser_on(o_laser_on), .o_job_run(o_job_run), .o_paused(o_paused),
	.o_spare_out_a(o_spare_out_a), .o_spare_out_b(o_spare_out_b), .o_min_led(o_min_led),
	.o_max_led(o_max_led), .o_min_hit(o_min_hit), .o_max_hit(o_max_hit));

//--- mioc_machine_side.sv
// Model of the pedal, door switch, fire button and limit switches at the connectors.
// Driven by task calls from the bench; pins change only just after a rising edge.
`timescale 1ns/1ps
module mioc_machine_side (
	// Clock
	input  wire       i_core_clk,
	// Pins toward the block
	output reg        o_pedal_in_n,
	output reg        o_protect_in,
	output reg        o_fire_in_n,
	output reg  [3:0] o_min_limit,
	output reg  [3:0] o_max_limit
);
	initial
	begin
		o_pedal_in_n = 1'b1;
		o_protect_in = 1'b0;
		o_fire_in_n  = 1'b1;
		o_min_limit  = 4'hF;
		o_max_limit  = 4'hF;
	end
	// Pressed pulls low, released goes back high
	task press(input int n);
		@(posedge i_core_clk);
		o_pedal_in_n <= 1'b0;
		repeat (n) @(posedge i_core_clk);
		o_pedal_in_n <= 1'b1;
	endtask
	task pins(input logic fire_n, input logic door, input logic [3:0] mn, input logic [3:0] mx);
		@(posedge i_core_clk);
		o_fire_in_n  <= fire_n;
		o_protect_in <= door;
		o_min_limit  <= mn;
		o_max_limit  <= mx;
	endtask
endmodule

//--- mioc_machine_io_control_test.sv
// Register-level bench for the machine I/O control block.
// Assumes the switch model beside it and a shortened pedal hold count.
`timescale 1ns/1ps
`include "mioc_regs.vh"
module mioc_machine_io_control_test;
	localparam PC = 8;
	logic        i_core_clk = 1'b0;
	logic        i_arst_n   = 1'b0;
	logic [3:0]  i_addr     = 4'h0;
	logic [31:0] i_wdata    = 32'h0;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	logic        i_spare_in = 1'b0;
	logic [2:0]  i_layer    = 3'h0;
	logic        i_homing   = 1'b0;
	logic [31:0] o_rdata;
	logic        o_irq, o_job_run, o_blower, o_laser_on, o_sa, o_sb, o_paused, ped_n, prot, fire_n;
	logic [3:0]  mnl, mxl, o_min_led, o_max_led, o_min_hit, o_max_hit;
	int          mismatches = 0;
	int          n_checks   = 0;
	always #10 i_core_clk = ~i_core_clk;
	mioc_machine_side u_ms (.i_core_clk(i_core_clk), .o_pedal_in_n(ped_n), .o_protect_in(prot),
		.o_fire_in_n(fire_n), .o_min_limit(mnl), .o_max_limit(mxl));
	mioc_machine_io_control #(.PEDAL_CYCLES(PC)) u_mioc_machine_io_control (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_pedal_in_n(ped_n),
		.i_protect_in(prot), .i_fire_in_n(fire_n), .i_spare_in(i_spare_in), .i_min_limit(mnl),
		.i_max_limit(mxl), .i_layer(i_layer), .i_homing(i_homing), .o_job_run(o_job_run),
		.o_blower(o_blower), .o_laser_on(o_laser_on), .o_spare_out_a(o_sa), .o_spare_out_b(o_sb),
		.o_min_led(o_min_led), .o_max_led(o_max_led), .o_min_hit(o_min_hit), .o_max_hit(o_max_hit),
		.o_paused(o_paused));
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe, so sample there
	task rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge i_core_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata & m, exp);
	endtask
	task tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	initial
	begin
		#1000000;
		mismatches++;
		close_out();
	end
	initial
	begin
		tick(12);
		chk({o_job_run, o_blower, o_laser_on, o_irq}, 4'h0);
		@(posedge i_core_clk) i_arst_n <= 1'b1;
		rd(`MIOC_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
		u_ms.press(3);
		tick(6);
		rd(`MIOC_OFF_STATUS, `MIOC_ST_IDLE, 32'h3);
		u_ms.press(PC + 2);
		tick(4);
		rd(`MIOC_OFF_STATUS, `MIOC_ST_RUN, 32'h3);
		chk(o_job_run, 1'b1);
		// A long press right after a short one starts too soon and is void
		u_ms.press(3);
		u_ms.press(PC + 2);
		tick(4);
		rd(`MIOC_OFF_STATUS, `MIOC_ST_RUN, 32'h3);
		i_spare_in <= 1'b1;
		wr(`MIOC_OFF_LAYER, 32'h4);
		i_layer <= 3'h2;
		wr(`MIOC_OFF_CTRL, 32'h1);
		tick(3);
		chk(o_blower, 1'b1);
		@(posedge i_core_clk) i_layer <= 3'h3;
		tick(3);
		chk(o_blower, 1'b0);
		wr(`MIOC_OFF_CTRL, 32'h8);
		tick(2);
		chk(o_blower, 1'b1);
		wr(`MIOC_OFF_CTRL, 32'h0);
		tick(2);
		chk(o_blower, 1'b0);
		u_ms.pins(1'b0, 1'b1, 4'hF, 4'hF);
		tick(5);
		chk(o_laser_on, 1'b1);
		rd(`MIOC_OFF_STATUS, `MIOC_ST_RUN, 32'h3);
		wr(`MIOC_OFF_CTRL, 32'h2);
		tick(5);
		chk({o_laser_on, o_job_run}, 2'b01);
		rd(`MIOC_OFF_STATUS, `MIOC_ST_PAUSE, 32'h3);
		u_ms.pins(1'b1, 1'b0, 4'hF, 4'hF);
		tick(4);
		u_ms.press(PC + 2);
		tick(4);
		rd(`MIOC_OFF_STATUS, `MIOC_ST_RUN, 32'h3);
		u_ms.press(PC + 2);
		tick(4);
		chk({o_paused, o_job_run}, 2'b11);
		wr(`MIOC_OFF_CTRL, 32'h42);
		tick(2);
		chk({o_job_run, o_irq}, 2'b00);
		// Pedal, protect trip and the stop are pending; the read clears them all
		rd(`MIOC_OFF_IRQ_STAT, 32'hB, 32'hF);
		wr(`MIOC_OFF_IRQ_MASK, 32'h8);
		wr(`MIOC_OFF_CTRL, 32'h12);
		tick(2);
		chk({o_job_run, o_irq}, 2'b10);
		wr(`MIOC_OFF_CTRL, 32'h82);
		tick(2);
		chk({o_job_run, o_irq}, 2'b01);
		rd(`MIOC_OFF_IRQ_STAT, 32'h8, 32'h8);
		tick(2);
		chk(o_irq, 1'b0);
		u_ms.pins(1'b1, 1'b0, 4'hE, 4'hB);
		tick(4);
		chk({o_max_led, o_min_led}, 8'h41);
		rd(`MIOC_OFF_INPUTS, 32'h20D, 32'hFFFFFFFF);
		@(posedge i_core_clk) i_homing <= 1'b1;
		tick(3);
		chk({o_max_hit, o_min_hit}, 8'h41);
		wr(`MIOC_OFF_CTRL, 32'h4);
		tick(3);
		chk({o_max_led, o_min_led}, 8'hBE);
		rd(4'hF, 32'h0, 32'hFFFFFFFF);
		chk({o_sa, o_sb}, 2'b00);
		close_out();
	end
endmodule
